// ### bcs_sequencer.v
// bcs_sequencer.v: gate sequencing, oscillator, sync, soft start and indicators.
// Analog comparators arrive as asynchronous levels and are synchronised here;
// the soft-start ramp is a digital count compared against a step-free target.
`include "bcs_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module bcs_sequencer #(
  parameter SS_SCALE = 1
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // analog comparator levels
  input wire enable_i,
  input wire vin_ok_i,
  input wire peak_reached_i,
  input wire above_light_load_i,
  input wire fb_above_ramp_i,
  input wire fb_low_i,
  input wire out_in_window_i,
  input wire fault_any_i,
  // sync pin
  input wire sync_in_i,
  output reg sync_out_o,
  output reg sync_oe_o,
  // switch drives
  output reg high_side_switch_o,
  output reg low_side_switch_o,
  // status
  output reg powered_o,
  output reg ss_done_o,
  output reg output_ok_indicator_oe_o,
  output reg fault_indicator_oe_o
);

  localparam ST_OFF = 2'h0;
  localparam ST_HS = 2'h1;
  localparam ST_DEAD = 2'h2;
  localparam ST_LS = 2'h3;

  // timing figures as integers, cut to register width on purpose where used
  localparam integer PER_DEF_I = `BCS_PERIOD_DEF;
  localparam integer PER_MAX_I = `BCS_PERIOD_MAX;
  localparam integer PER_MIN_I = `BCS_PERIOD_MIN;
  localparam integer DEAD_LOAD_I = `BCS_DEAD_CYC - 1;

  // two-flop synchronisers for all asynchronous inputs
  localparam NS = 9;
  wire [NS-1:0] async_in;
  reg [NS-1:0] meta_reg;
  reg [NS-1:0] sync_reg;
  assign async_in = {sync_in_i, fault_any_i, out_in_window_i, fb_low_i, fb_above_ramp_i,
                     above_light_load_i, peak_reached_i, vin_ok_i, enable_i};
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_sync
      always @(posedge mclk_i) begin
        meta_reg[g] <= async_in[g];
        sync_reg[g] <= meta_reg[g];
      end
    end
  endgenerate
  wire en_s = sync_reg[0];
  wire vin_s = sync_reg[1];
  wire peak_s = sync_reg[2];
  wire above_ll_s = sync_reg[3];
  wire fb_above_s = sync_reg[4];
  wire fb_low_s = sync_reg[5];
  wire win_s = sync_reg[6];
  wire fault_s = sync_reg[7];
  wire sync_s = sync_reg[8];

  // software settings
  reg [15:0] ctrl_reg;
  reg [15:0] period_reg;
  reg [1:0] ss_sel_reg;
  wire skip_mode = ctrl_reg[`BCS_CTRL_SKIP_BIT];
  wire sync_as_out = ctrl_reg[`BCS_CTRL_SYNC_OUT_BIT];
  wire phase_180 = ctrl_reg[`BCS_CTRL_PHASE_BIT];

  // out-of-range period writes are clamped so the oscillator stays legal
  reg [15:0] period_next;
  always @* begin
    period_next = wdata_i;
    if (wdata_i > PER_MAX_I[15:0])
      period_next = PER_MAX_I[15:0];
    else if (wdata_i < PER_MIN_I[15:0])
      period_next = PER_MIN_I[15:0];
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg <= `BCS_CTRL_RESET;
      period_reg <= PER_DEF_I[15:0];
      ss_sel_reg <= `BCS_SS_SEL_RESET;
    end else if (wr_i) begin
      case (addr_i)
        `BCS_ADDR_CTRL: ctrl_reg <= {13'h0000, wdata_i[2:0]};
        `BCS_ADDR_PERIOD: period_reg <= period_next;
        `BCS_ADDR_SS: ss_sel_reg <= wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // power gating: enable and lockout, recovers on its own when both return
  wire power_on = en_s & vin_s;

  // external sync detection: rising edges, lost after a quiet timeout
  reg sync_d_reg;
  reg [8:0] sync_age_reg;
  wire sync_rise = sync_s & ~sync_d_reg;
  wire sync_present = ~sync_as_out & (sync_age_reg < `BCS_SYNC_LOSS_CYC);
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sync_d_reg <= 1'b0;
      sync_age_reg <= 9'h1FF;
    end else begin
      sync_d_reg <= sync_s;
      if (sync_rise)
        sync_age_reg <= 9'h000;
      else if (sync_age_reg != 9'h1FF)
        sync_age_reg <= sync_age_reg + 9'h001;
    end
  end

  // soft start ramp and pre-bias
  reg [17:0] ss_cnt_reg;
  reg ss_done_reg;
  reg [17:0] ss_len;
  always @* begin
    case (ss_sel_reg)
      2'h0: ss_len = 18'd20000;
      2'h1: ss_len = 18'd40000;
      2'h2: ss_len = 18'd80000;
      default: ss_len = 18'd160000;
    endcase
    ss_len = ss_len / SS_SCALE[17:0];
  end
  always @(posedge mclk_i) begin
    if (rst_i || !power_on || fb_low_s) begin
      ss_cnt_reg <= 18'h0_0000;
      ss_done_reg <= 1'b0;
    end else if (!ss_done_reg) begin
      if (ss_cnt_reg >= ss_len)
        ss_done_reg <= 1'b1;
      else
        ss_cnt_reg <= ss_cnt_reg + 18'h0_0001;
    end
  end
  wire ext_clk_use = sync_present & ss_done_reg;
  wire prebias_hold = ~ss_done_reg & fb_above_s;
  wire run = power_on & ~prebias_hold;

  // internal oscillator with sleep blocking and crossing restart
  reg [15:0] osc_cnt_reg;
  reg sleep_reg;
  reg above_d_reg;
  wire skip_active = skip_mode & ~sync_present;
  wire wake = skip_active & sleep_reg & above_ll_s & ~above_d_reg;
  wire int_tick = (osc_cnt_reg == period_reg - 16'h0001) & ~sleep_reg;
  wire cyc_start = run & (ext_clk_use ? sync_rise : (int_tick | wake));
  always @(posedge mclk_i) begin
    if (rst_i || !power_on) begin
      osc_cnt_reg <= 16'h0000;
      sleep_reg <= 1'b0;
      above_d_reg <= 1'b0;
    end else begin
      above_d_reg <= above_ll_s;
      if (wake || int_tick)
        osc_cnt_reg <= 16'h0000;
      else if (!sleep_reg)
        osc_cnt_reg <= osc_cnt_reg + 16'h0001;
      if (!skip_active || wake)
        sleep_reg <= 1'b0;
      else if (int_tick && !above_ll_s)
        sleep_reg <= 1'b1;
    end
  end

  // gate sequencer
  reg [1:0] st_reg;
  reg [1:0] st_next;
  reg [2:0] dead_cnt_reg;
  reg dead_to_hs_reg;
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF: if (cyc_start) st_next = ST_HS;
      ST_HS: if (!run) st_next = ST_OFF;
        else if (peak_s) st_next = ST_DEAD;
      ST_DEAD: if (!run) st_next = ST_OFF;
        else if (dead_cnt_reg == 3'h0) st_next = dead_to_hs_reg ? ST_HS : ST_LS;
      ST_LS: if (!run) st_next = ST_OFF;
        else if (cyc_start) st_next = ST_DEAD;
      default: st_next = ST_OFF;
    endcase
  end
  always @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg <= ST_OFF;
      dead_cnt_reg <= 3'h0;
      dead_to_hs_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (st_next == ST_DEAD && st_reg != ST_DEAD) begin
        dead_cnt_reg <= DEAD_LOAD_I[2:0];
        dead_to_hs_reg <= (st_reg == ST_LS);
      end else if (dead_cnt_reg != 3'h0)
        dead_cnt_reg <= dead_cnt_reg - 3'h1;
    end
  end

  // output ok qualify timer
  reg [10:0] pg_cnt_reg;
  always @(posedge mclk_i) begin
    if (rst_i || !ss_done_reg || !win_s)
      pg_cnt_reg <= 11'h000;
    else if (pg_cnt_reg != `BCS_PG_DELAY_CYC)
      pg_cnt_reg <= pg_cnt_reg + 11'h001;
  end

  // sync output: 180 degrees toggles at half period
  reg sync_q_reg;
  always @(posedge mclk_i) begin
    if (rst_i)
      sync_q_reg <= 1'b0;
    else
      sync_q_reg <= (osc_cnt_reg < {1'b0, period_reg[15:1]}) ^ phase_180;
  end

  // registered outputs; switches only follow the sequencer state
  always @(posedge mclk_i) begin
    if (rst_i) begin
      high_side_switch_o <= 1'b0;
      low_side_switch_o <= 1'b0;
      sync_out_o <= 1'b0;
      sync_oe_o <= 1'b0;
      powered_o <= 1'b0;
      ss_done_o <= 1'b0;
      output_ok_indicator_oe_o <= 1'b1;
      fault_indicator_oe_o <= 1'b0;
    end else begin
      high_side_switch_o <= (st_next == ST_HS);
      low_side_switch_o <= (st_next == ST_LS);
      sync_out_o <= sync_as_out & sync_q_reg;
      sync_oe_o <= sync_as_out;
      powered_o <= power_on;
      ss_done_o <= ss_done_reg;
      output_ok_indicator_oe_o <= (pg_cnt_reg != `BCS_PG_DELAY_CYC);
      fault_indicator_oe_o <= fault_s;
    end
  end

  // read port: data one cycle after the strobe, zero for unmapped
  always @(posedge mclk_i) begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (rd_i) begin
      case (addr_i)
        `BCS_ADDR_CTRL: rdata_o <= ctrl_reg;
        `BCS_ADDR_PERIOD: rdata_o <= period_reg;
        `BCS_ADDR_SS: rdata_o <= {14'h0000, ss_sel_reg};
        `BCS_ADDR_STATUS: rdata_o <= {9'h000, sleep_reg, st_reg, ext_clk_use, ss_done_reg, prebias_hold, power_on};
        `BCS_ADDR_SYNCMON: rdata_o <= {15'h0000, sync_present};
        default: rdata_o <= 16'h0000;
      endcase
    end else
      rdata_o <= 16'h0000;
  end

endmodule
`default_nettype wire

// ### bcs_regs.vh
// bcs_regs.vh: register offsets, field positions, reset values and timing counts
// for the step-down converter control sequencer; assumes a 40 MHz clock.
//
// Overview of operation
// - cycle clock edge turns high-side switch on
// - low-side follows high-side off until next cycle
// - dead interval separates the two switches
// - unreached peak keeps high-side on, skipping turn-off
// - software selects pulse-skip or forced continuous mode
// - pulse-skip sleeps below light-load threshold
// - threshold crossing restarts the cycle clock
// - forced continuous never skips a pulse
// - turn-on input powers converter up and down
// - oscillator defaults 600kHz, range 150kHz-2.2MHz
// - sync pin is clock input or output
// - external sync used only after soft start
// - present sync clock forces continuous mode
// - sync output phase selectable 0 or 180 degrees
// - input lockout gates power, never latches
// - soft-start ramp is reference until it passes target
// - soft start 1ms default; 0.5, 1, 2, 4ms
// - output short discharges ramp, restarts soft start
// - pre-bias holds both switches off until ramp passes
// - output ok low until soft start, 30us qualify
// - any fault or warning pulls fault indicator low
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// register offsets (word index on the plain port)
`define BCS_ADDR_CTRL 4'h0
`define BCS_ADDR_PERIOD 4'h1
`define BCS_ADDR_SS 4'h2
`define BCS_ADDR_STATUS 4'h3
`define BCS_ADDR_SYNCMON 4'h4

// control register fields
`define BCS_CTRL_SKIP_BIT 0
`define BCS_CTRL_SYNC_OUT_BIT 1
`define BCS_CTRL_PHASE_BIT 2
`define BCS_CTRL_RESET 16'h0000

// clock and frequency figures
`define BCS_CLK_KHZ 40000
`define BCS_FREQ_DEF_KHZ 600
`define BCS_FREQ_MIN_KHZ 150
`define BCS_FREQ_MAX_KHZ 2200
`define BCS_PERIOD_DEF (`BCS_CLK_KHZ / `BCS_FREQ_DEF_KHZ)
`define BCS_PERIOD_MAX (`BCS_CLK_KHZ / `BCS_FREQ_MIN_KHZ)
`define BCS_PERIOD_MIN ((`BCS_CLK_KHZ + `BCS_FREQ_MAX_KHZ - 1) / `BCS_FREQ_MAX_KHZ)

// dead interval and sync loss timeout in cycles
`define BCS_DEAD_CYC 4
`define BCS_SYNC_LOSS_CYC 400

// soft start: select codes and durations in microseconds
`define BCS_SS_SEL_RESET 2'h1
`define BCS_SS_US_0 500
`define BCS_SS_US_1 1000
`define BCS_SS_US_2 2000
`define BCS_SS_US_3 4000
`define BCS_CYC_PER_US (`BCS_CLK_KHZ / 1000)

// output ok qualify delay
`define BCS_PG_DELAY_US 30
`define BCS_PG_DELAY_CYC (`BCS_PG_DELAY_US * `BCS_CYC_PER_US)

`endif

// ### bcs_sequencer_props.sv
// bcs_sequencer_props.sv: port checks for the converter sequencer
// assumes bind onto bcs_sequencer, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
module bcs_sequencer_props (
  // clock, reset, register port
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  // levels and drives
  input wire logic fault_any_i,
  input wire logic sync_oe_o,
  input wire logic high_side_switch_o,
  input wire logic low_side_switch_o,
  input wire logic powered_o,
  input wire logic ss_done_o,
  input wire logic output_ok_indicator_oe_o,
  input wire logic fault_indicator_oe_o
);
  localparam int PGD = `BCS_PG_DELAY_CYC;
  int ss_cnt = 0;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // cycles since soft start ended; output ok may not release sooner
  always @(posedge mclk_i) ss_cnt <= (rst_i || !ss_done_o) ? 0 : ss_cnt + 1;
  // steps: high side turning off, software asking for sync out
  sequence s_hs_off; $fell(high_side_switch_o) && powered_o; endsequence
  sequence s_sync_out; wr_i && addr_i == 4'h0 && wdata_i[1]; endsequence
  property p_ovl; !(high_side_switch_o && low_side_switch_o); endproperty
  a_ovl: assert property (p_ovl) else $error("switch overlap");
  property p_dead; s_hs_off |-> !low_side_switch_o [*3]; endproperty
  a_dead: assert property (p_dead) else $error("no dead gap");
  property p_ls; s_hs_off |-> ##[1:8] (low_side_switch_o || !powered_o || !ss_done_o); endproperty
  a_ls: assert property (p_ls) else $error("low side late");
  property p_off; !powered_o [*3] |-> !high_side_switch_o && !low_side_switch_o; endproperty
  a_off: assert property (p_off) else $error("switch while off");
  property p_okl; !ss_done_o [*2] |-> output_ok_indicator_oe_o; endproperty
  a_okl: assert property (p_okl) else $error("ok before ss");
  property p_okq; $fell(output_ok_indicator_oe_o) |-> ss_cnt >= PGD - 4; endproperty
  a_okq: assert property (p_okq) else $error("ok too early");
  property p_fon; fault_any_i [*5] |-> fault_indicator_oe_o; endproperty
  a_fon: assert property (p_fon) else $error("fault not shown");
  property p_foff; !fault_any_i [*5] |-> !fault_indicator_oe_o; endproperty
  a_foff: assert property (p_foff) else $error("fault stuck");
  property p_so; s_sync_out |-> ##[1:3] sync_oe_o; endproperty
  a_so: assert property (p_so) else $error("sync not out");
endmodule
bind bcs_sequencer bcs_sequencer_props i_bcs_sequencer_props (.*);
`default_nettype wire

// ### bcs_far_side.sv
// bcs_far_side.sv: peak-current comparator and sync clock source
// assumes the high-side drive and the 40 MHz clock of the bench
`timescale 1ns/1ps
`default_nettype none
module bcs_far_side (
  // clock and controls
  input wire logic mclk_i,
  input wire logic hs_i,
  input wire logic stuck_i,
  input wire logic sync_en_i,
  // comparator and sync pin
  output var logic peak_o,
  output var logic sync_o
);
  int t = 0;
  int s = 0;
  initial peak_o = 1'b0;
  initial sync_o = 1'b0;
  // current trips 10 cycles into conduction unless the load is stuck high
  // sync is 1 MHz, 250 ns high, and stays low while off
  always @(posedge mclk_i) begin
    t <= (hs_i === 1'b1) ? t + 1 : 0;
    peak_o <= (hs_i === 1'b1) && !stuck_i && t >= 9;
    s <= (s == 39) ? 0 : s + 1;
    sync_o <= sync_en_i && s < 10;
  end
endmodule
`default_nettype wire

// ### bcs_sequencer_test.sv
// bcs_sequencer_test.sv: self-checking bench for the converter sequencer
// assumes bcs_far_side models the current comparator and sync source
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module bcs_sequencer_test;
  typedef struct {logic w; logic [3:0] a; logic [15:0] d, e;} bcs_row_t;
  localparam int SS = `BCS_SS_US_0 * `BCS_CYC_PER_US / 100;
  logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, enable_i = 1'b0, vin_ok_i = 1'b0;
  logic above_light_load_i = 1'b1, fb_above_ramp_i = 1'b0, fb_low_i = 1'b0, out_in_window_i = 1'b1;
  logic fault_any_i = 1'b0, stuck = 1'b0, sen = 1'b0, hs_q = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rv;
  wire logic [15:0] rdata_o;
  wire logic peak_reached_i, sync_in_i, sync_out_o, sync_oe_o, high_side_switch_o, low_side_switch_o;
  wire logic powered_o, ss_done_o, output_ok_indicator_oe_o, fault_indicator_oe_o;
  int num_checks = 0, n_fail = 0, n_hs = 0, n;
  // reset values, clamps, all soft-start codes, an unmapped place
  bcs_row_t rows[12] = '{'{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h1, 16'h0000, 16'h0042},
    '{1'b0, 4'h2, 16'h0000, 16'h0001}, '{1'b1, 4'h1, 16'h0005, 16'h0013},
    '{1'b1, 4'h1, 16'h0400, 16'h010a}, '{1'b1, 4'h1, 16'h0042, 16'h0042},
    '{1'b1, 4'h2, 16'h0003, 16'h0003}, '{1'b1, 4'h2, 16'h0002, 16'h0002},
    '{1'b1, 4'h2, 16'h0000, 16'h0000}, '{1'b1, 4'h0, 16'h0005, 16'h0005},
    '{1'b1, 4'h0, 16'h0000, 16'h0000}, '{1'b1, 4'h7, 16'h1234, 16'h0000}};
  bcs_sequencer #(.SS_SCALE(100)) i_bcs_sequencer (.*);
  bcs_far_side i_bcs_far_side (.mclk_i(mclk_i), .hs_i(high_side_switch_o), .stuck_i(stuck),
    .sync_en_i(sen), .peak_o(peak_reached_i), .sync_o(sync_in_i));
  initial forever #12.5 mclk_i = ~mclk_i;
  // count high-side starts
  always @(posedge mclk_i) begin
    hs_q <= high_side_switch_o;
    if (high_side_switch_o === 1'b1 && hs_q === 1'b0) n_hs <= n_hs + 1;
  end
  task cyc(input int k); repeat (k) @(posedge mclk_i); #1; endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i); wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge mclk_i); wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk_i); rd_i <= 1'b1; addr_i <= a;
    @(posedge mclk_i); rd_i <= 1'b0; #1 rv = rdata_o;
  endtask
  // bounded wait for soft start to finish
  task wss; n = 0; while (ss_done_o !== 1'b1 && n < 5000) begin cyc(1); n++; end endtask
  task close_out;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard, well above the expected run of some 4000 cycles
  initial begin #500_000; n_fail++; close_out(); end
  initial begin
    cyc(6); rst_i <= 1'b0; cyc(1);
    `CHK({high_side_switch_o, low_side_switch_o, sync_oe_o, output_ok_indicator_oe_o}, 4'b0001)
    `CHK({fault_indicator_oe_o, powered_o}, 2'b00)
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK(rv, rows[i].e)
    end
    $display("registers done");
    enable_i <= 1'b1; vin_ok_i <= 1'b1; wss();
    `CHK(n inside {[SS - 5:SS + 20]}, 1'b1)
    n_hs = 0; cyc(1320);
    `CHK(n_hs inside {[19:21]}, 1'b1)
    `CHK(output_ok_indicator_oe_o, 1'b0)
    out_in_window_i <= 1'b0; cyc(6);
    `CHK(output_ok_indicator_oe_o, 1'b1)
    out_in_window_i <= 1'b1; wr(4'h0, 16'h0001); above_light_load_i <= 1'b0; cyc(100);
    n_hs = 0; cyc(500);
    `CHK(n_hs, 0)
    above_light_load_i <= 1'b1; cyc(12);
    `CHK(n_hs, 1)
    wr(4'h0, 16'h0000); stuck <= 1'b1; cyc(200);
    `CHK({high_side_switch_o, low_side_switch_o}, 2'b10)
    stuck <= 1'b0; wr(4'h0, 16'h0001); above_light_load_i <= 1'b0; sen <= 1'b1; cyc(450);
    n_hs = 0; cyc(400);
    `CHK(n_hs inside {[9:11]}, 1'b1)
    sen <= 1'b0; above_light_load_i <= 1'b1; wr(4'h0, 16'h0002); cyc(3);
    `CHK(sync_oe_o, 1'b1)
    @(posedge high_side_switch_o); #1; `CHK(sync_out_o, 1'b1)
    wr(4'h0, 16'h0006); @(posedge high_side_switch_o); #1; `CHK(sync_out_o, 1'b0)
    fault_any_i <= 1'b1; cyc(6);
    `CHK(fault_indicator_oe_o, 1'b1)
    fault_any_i <= 1'b0; vin_ok_i <= 1'b0; cyc(6);
    `CHK({fault_indicator_oe_o, powered_o, high_side_switch_o, low_side_switch_o}, 4'h0)
    vin_ok_i <= 1'b1; wss();
    `CHK(powered_o, 1'b1)
    fb_low_i <= 1'b1; cyc(8);
    `CHK(ss_done_o, 1'b0)
    fb_low_i <= 1'b0; fb_above_ramp_i <= 1'b1; cyc(60);
    `CHK({high_side_switch_o, low_side_switch_o}, 2'b00)
    fb_above_ramp_i <= 1'b0; wss();
    `CHK(ss_done_o, 1'b1)
    enable_i <= 1'b0; cyc(6);
    `CHK(powered_o, 1'b0)
    $display("sequencing done");
    close_out();
  end
endmodule
`default_nettype wire
